//--- hdl/rfsr_pkg.sv
// Constants and state types for the regulator fault and status registers.
// Assumes a 100 MHz logic clock and a byte-wide register port from the serial engine.

package rfsr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FAULT_EVENT_ADDR = 8'h01;
  localparam logic [7:0] LIVE_STATUS_ADDR = 8'h02;
  localparam logic [7:0] FAULT_EVENT_RESET = 8'h00;
  localparam logic [7:0] LIVE_STATUS_RESET = 8'h10;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_STARTUP_BIT = 4;
  localparam int FLAG_UNDERVOLT_BIT = 3;
  localparam int FLAG_THERMAL_BIT = 2;
  localparam int FLAG_SHORT_BIT = 1;
  localparam int FLAG_PEAK_BIT = 0;
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_BYPASS_BIT = 5;
  localparam int STAT_SCHEME_BIT = 4;
  localparam int STAT_UNDERVOLT_BIT = 3;
  localparam int STAT_THERMAL_BIT = 2;
  localparam int STAT_SHORT_BIT = 1;
  localparam int STAT_PEAK_BIT = 0;
  localparam int FLAG_COUNT = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PEAK_PERSIST_NS = 1000;
  localparam int PEAK_PERSIST_CYCLES_INT = (PEAK_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PEAK_PERSIST_CYCLES = PEAK_PERSIST_CYCLES_INT[7:0];
  localparam logic [7:0] PEAK_COUNT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FLAG_COUNT-1:0] flags;
    logic [7:0] rdData;
    logic rdValid;
    logic pending;
  } rfsr_regs_state_t;

  typedef struct packed {
    logic [7:0] count;
    logic done;
  } rfsr_peak_state_t;

endpackage

//--- hdl/rfsr_peak_filter.sv
// Persistence filter for the peak current limit comparator.
// Assumes the comparator level is synchronous to sys_clk.

`timescale 1ns/1ps
`default_nettype none

module rfsr_peak_filter
  import rfsr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Comparator and result
  input wire logic peakLimitHit,
  output logic persistDone
);

  rfsr_peak_state_t st_ff;
  rfsr_peak_state_t nxt_st;

  // ----------------------------------------------------------------
  // Count consecutive cycles, one pulse per sustained episode
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!peakLimitHit)
    begin
      nxt_st.count = PEAK_COUNT_RESET;
    end
    else if (st_ff.count < PEAK_PERSIST_CYCLES)
    begin
      nxt_st.count = st_ff.count + 8'h01;
      nxt_st.done = (st_ff.count == PEAK_PERSIST_CYCLES - 8'h01); // [R05]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_ff <= '{count: PEAK_COUNT_RESET, done: 1'b0};
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign persistDone = st_ff.done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  persist_pulse_a: assert property (ce && peakLimitHit // [R05]
    && st_ff.count == PEAK_PERSIST_CYCLES - 8'h01 |=> persistDone)
    else $error("peak persistence pulse missing");
  persist_early_a: assert property (ce && !peakLimitHit // [R05]
    |=> !persistDone && st_ff.count == 8'h00)
    else $error("peak persistence fired without comparator");

endmodule
`default_nettype wire

//--- hdl/rfsr_regs.sv
// Fault event and live status registers of the step-down regulator.
// Assumes the serial engine presents synchronous byte reads; condition inputs are
// synchronous levels from the analog front end.
//
// Summary of operation
// R01: A startup timeout fault sets bit 4 of the fault event register until a read clears it.
// R02: An input undervoltage fault sets bit 3 of the fault event register until a read clears it.
// R03: An overtemperature fault sets bit 2 of the fault event register until a read clears it.
// R04: An output short fault sets bit 1 of the fault event register until a read clears it.
// R05: Peak current limit hit continuously for the set duration sets bit 0 until read.
// R06: Status bit 6 reads one only while idle, input voltage good and die temperature safe.
// R07: Status bit 5 reads one in pass-through and zero in normal switching.
// R08: Status bit 4 reads zero in pulse-frequency and one in fixed-frequency operation.
// R09: Status bit 3 shows the live undervoltage comparator, zero while input is good.
// R10: Status bit 3 reads one whenever input voltage is below the undervoltage threshold.
// R11: Status bit 2 reads one while the die is too hot and zero while it is safe.
// R12: Status bit 1 reads one while shorted or recovering, and zero when the converter is off.
// R13: Status bit 0 reads one while the converter is hitting its peak current limit.
// R14: Unused bits read zero and host writes change no state in either register.
// R15: Status bits are live, and a fault in the cycle of a clearing read stays set.

`timescale 1ns/1ps
`default_nettype none

module rfsr_regs
  import rfsr_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port from the serial engine
  input wire logic regRdStrobe,
  input wire logic [7:0] regAddr,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Fault events, high while a fault is declared
  input wire logic startupTimeoutFault,
  input wire logic undervoltageFault,
  input wire logic thermalFault,
  input wire logic outputShortFault,
  // Live conditions
  input wire logic peakLimitHit,
  input wire logic deviceIdle,
  input wire logic passThrough,
  input wire logic fixedFrequency,
  input wire logic undervoltageLive,
  input wire logic thermalCompLive,
  input wire logic shortCompLive,
  input wire logic converterEnabled,
  // Summary
  output logic faultPending
);

  rfsr_regs_state_t st_ff;
  rfsr_regs_state_t nxt_st;
  logic peakPersist;
  logic [FLAG_COUNT-1:0] faultEvents;
  logic [7:0] faultImage;
  logic [7:0] statusImage;
  logic clearFlags;

  // ----------------------------------------------------------------
  // Peak current persistence
  // ----------------------------------------------------------------
  rfsr_peak_filter peakFilter
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .peakLimitHit(peakLimitHit),
    .persistDone(peakPersist)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb
  begin
    faultEvents = '0;
    faultEvents[FLAG_STARTUP_BIT] = startupTimeoutFault; // [R01]
    faultEvents[FLAG_UNDERVOLT_BIT] = undervoltageFault; // [R02]
    faultEvents[FLAG_THERMAL_BIT] = thermalFault; // [R03]
    faultEvents[FLAG_SHORT_BIT] = outputShortFault; // [R04]
    faultEvents[FLAG_PEAK_BIT] = peakPersist; // [R05]
  end

  always_comb
  begin
    faultImage = FAULT_EVENT_RESET;
    faultImage[FLAG_COUNT-1:0] = st_ff.flags; // [R14]
  end

  always_comb
  begin
    statusImage = 8'h00; // [R14]
    statusImage[STAT_READY_BIT] = deviceIdle && !undervoltageLive && !thermalCompLive; // [R06]
    statusImage[STAT_BYPASS_BIT] = passThrough; // [R07]
    statusImage[STAT_SCHEME_BIT] = fixedFrequency; // [R08]
    statusImage[STAT_UNDERVOLT_BIT] = undervoltageLive; // [R09] [R10]
    statusImage[STAT_THERMAL_BIT] = thermalCompLive; // [R11]
    statusImage[STAT_SHORT_BIT] = shortCompLive && converterEnabled; // [R12]
    statusImage[STAT_PEAK_BIT] = peakLimitHit; // [R13]
  end

  assign clearFlags = regRdStrobe && (regAddr == FAULT_EVENT_ADDR);

  // ----------------------------------------------------------------
  // Next state: read decode and sticky flags
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdValid = regRdStrobe;
    if (!regRdStrobe)
    begin
      nxt_st.rdData = st_ff.rdData;
    end
    else if (regAddr == FAULT_EVENT_ADDR)
    begin
      nxt_st.rdData = faultImage; // [R01] [R02] [R03] [R04] [R05]
    end
    else if (regAddr == LIVE_STATUS_ADDR)
    begin
      nxt_st.rdData = statusImage; // [R15]
    end
    else
    begin
      nxt_st.rdData = READ_IDLE_VALUE;
    end
    // Set wins over the clearing read; nothing else alters the flags
    nxt_st.flags = (st_ff.flags & ~{FLAG_COUNT{clearFlags}}) | faultEvents; // [R15] [R14]
    nxt_st.pending = |nxt_st.flags;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_ff <= '{flags: '0, rdData: READ_IDLE_VALUE, rdValid: 1'b0, pending: 1'b0};
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign regRdValid = st_ff.rdValid;
  assign faultPending = st_ff.pending;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  startup_flag_a: assert property (ce && startupTimeoutFault |=> st_ff.flags[FLAG_STARTUP_BIT]) // [R01]
    else $error("startup flag not set");

  undervolt_flag_a: assert property (ce && undervoltageFault ##1 !ce // [R02]
    |-> st_ff.flags[FLAG_UNDERVOLT_BIT])
    else $error("undervoltage flag not held while frozen");

  thermal_hold_a: assert property (ce && thermalFault ##1 (!(ce && clearFlags)) [*2] // [R03]
    |-> st_ff.flags[FLAG_THERMAL_BIT])
    else $error("thermal flag dropped without read");

  short_flag_a: assert property (ce && outputShortFault |=> st_ff.flags[FLAG_SHORT_BIT]) // [R04]
    else $error("short flag not set");

  peak_flag_a: assert property (ce && peakPersist |=> st_ff.flags[FLAG_PEAK_BIT]) // [R05]
    else $error("peak flag not set");

  read_clear_a: assert property (ce && clearFlags && faultEvents == '0 // [R01]
    |=> st_ff.flags == '0 && regRdValid && regRdData == {3'b000, $past(st_ff.flags)})
    else $error("fault read did not return and clear flags");

  ready_read_a: assert property (ce && regRdStrobe && regAddr == LIVE_STATUS_ADDR // [R06]
    |=> regRdData[STAT_READY_BIT] ==
        ($past(deviceIdle) && !$past(undervoltageLive) && !$past(thermalCompLive)))
    else $error("ready bit wrong");

  status_live_a: assert property (ce && regRdStrobe // [R07] [R08] [R09] [R10]
    && regAddr == LIVE_STATUS_ADDR
    |=> regRdData[5:3] == {$past(passThrough), $past(fixedFrequency), $past(undervoltageLive)})
    else $error("bypass, scheme or undervoltage bit wrong");

  thermal_read_a: assert property (ce && regRdStrobe && regAddr == LIVE_STATUS_ADDR // [R11]
    |=> regRdData[STAT_THERMAL_BIT] == $past(thermalCompLive))
    else $error("thermal live bit wrong");

  short_off_a: assert property (ce && regRdStrobe && regAddr == LIVE_STATUS_ADDR // [R12]
    && !converterEnabled |=> !regRdData[STAT_SHORT_BIT])
    else $error("short bit set while disabled");

  peak_live_a: assert property (ce && regRdStrobe && regAddr == LIVE_STATUS_ADDR // [R13]
    |=> regRdData[STAT_PEAK_BIT] == $past(peakLimitHit))
    else $error("peak live bit wrong");

  unused_zero_a: assert property (regRdValid |-> regRdData[7] == 1'b0 && // [R14]
    (regRdData[6:5] == 2'b00 || $past(regAddr) == LIVE_STATUS_ADDR))
    else $error("unused bits not zero");

  set_wins_a: assert property (ce && clearFlags && thermalFault // [R15]
    |=> st_ff.flags[FLAG_THERMAL_BIT] ##1 (ce ? 1'b1 : st_ff.flags[FLAG_THERMAL_BIT]))
    else $error("fault lost against clearing read");

  frozen_read_a: assert property (!ce && clearFlags // [R02]
    |=> st_ff.flags == $past(st_ff.flags))
    else $error("flags changed while clock enable low");

  unmapped_zero_a: assert property (ce && regRdStrobe && regAddr != FAULT_EVENT_ADDR // [R14]
    && regAddr != LIVE_STATUS_ADDR |=> regRdValid && regRdData == READ_IDLE_VALUE)
    else $error("unmapped read not zero");

  flag_read_c: cover property (ce && clearFlags && st_ff.flags != '0);
  set_clear_c: cover property (ce && clearFlags && faultEvents != '0);
  ready_c: cover property (ce && regRdStrobe && regAddr == LIVE_STATUS_ADDR && statusImage[6]);
  peak_c: cover property (peakPersist);
  frozen_read_c: cover property (!ce && regRdStrobe);

endmodule
`default_nettype wire

//--- verification/rfsr_host_model.sv
// Host side model that issues single-byte reads on the register port.
// Assumes the register port samples requests on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module rfsr_host_model
(
  // Clock
  input wire logic sys_clk,
  // Register read request
  output logic regRdStrobe,
  output logic [7:0] regAddr
);
  initial
  begin
    regRdStrobe = 1'b0;
    regAddr = 8'h00;
  end

  // One read, held across exactly one sampling edge; address then scrambled
  task automatic doRead(input logic [7:0] a);
    @(posedge sys_clk);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule

`default_nettype wire

//--- verification/regulator_fault_status_regs_tb_top.sv
// Self-checking bench for the fault event and live status registers.
// Assumes rfsr_regs, rfsr_pkg and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module regulator_fault_status_regs_tb_top
  import rfsr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] faultIn = 4'h0;
  logic [7:0] cond = 8'h10;
  logic regRdStrobe;
  logic [7:0] regAddr;
  logic [7:0] regRdData;
  logic regRdValid;
  logic faultPending;
  logic [7:0] expQ[$];
  logic [15:0] rnd = 16'hef52;
  int nErrors = 0;
  int checked = 0;

  always #5 sys_clk = ~sys_clk;

  rfsr_host_model host_u (.sys_clk(sys_clk), .regRdStrobe(regRdStrobe), .regAddr(regAddr));

  rfsr_regs dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .regRdStrobe(regRdStrobe), .regAddr(regAddr),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .startupTimeoutFault(faultIn[3]), .undervoltageFault(faultIn[2]),
    .thermalFault(faultIn[1]), .outputShortFault(faultIn[0]),
    .peakLimitHit(cond[7]), .deviceIdle(cond[6]), .passThrough(cond[5]),
    .fixedFrequency(cond[4]), .undervoltageLive(cond[3]), .thermalCompLive(cond[2]),
    .shortCompLive(cond[1]), .converterEnabled(cond[0]), .faultPending(faultPending)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] stat(input logic [7:0] c);
    return {1'b0, c[6] & ~c[3] & ~c[2], c[5], c[4], c[3], c[2], c[1] & c[0], c[7]};
  endfunction

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      nErrors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      nErrors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host_u.doRead(a);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Answers are matched against the oldest expectation, mid-cycle where settled
  always @(negedge sys_clk)
  begin
    if (regRdValid === 1'b1)
    begin
      if (expQ.size() == 0)
        chk8(8'hxx, regRdData);
      else
        chk8(expQ.pop_front(), regRdData);
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h10);
    rd(8'h00, 8'h00);
    rd(8'hff, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      faultIn <= 4'(1 << i);
      @(posedge sys_clk);
      faultIn <= 4'h0;
      @(negedge sys_clk);
      chk1(1'b1, faultPending);
      rd(8'h01, 8'(2 << i));
      @(negedge sys_clk);
      chk1(1'b0, faultPending);
      rd(8'h01, 8'h00);
    end
    @(posedge sys_clk);
    faultIn <= 4'h2;
    rd(8'h01, 8'h04);
    faultIn <= 4'h0;
    rd(8'h01, 8'h04);
    rd(8'h01, 8'h00);
    $display("test event flags done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      cond <= 8'h90;
      repeat (int'(PEAK_PERSIST_CYCLES) - 1 + k) @(posedge sys_clk);
      cond <= 8'h10;
      rd(8'h01, 8'(k));
    end
    $display("test peak persistence done");
    // Latch a flag, then freeze: a read issued while frozen must not clear it
    @(posedge sys_clk);
    faultIn <= 4'h4;
    @(posedge sys_clk);
    faultIn <= 4'h0;
    ce <= 1'b0;
    host_u.doRead(8'h01);
    ce <= 1'b1;
    rd(8'h01, 8'h08);
    $display("test clock enable freeze done");
    repeat (24)
    begin
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      cond <= rnd[7:0];
      rd(8'h02, stat(rnd[7:0]));
    end
    $display("test live status done");
    repeat (3) @(posedge sys_clk);
    if (expQ.size() != 0)
      nErrors++;
    stop_test();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    nErrors++;
    stop_test();
  end
endmodule

`default_nettype wire
